// ==== logic/angle_readout_pkg.sv ====
package angle_readout_pkg;

    // sys_clk period
    localparam int CLK_PERIOD_NS = 5;

    // serial clock idle time that ends a frame (least figure)
    localparam int TIMEOUT_NS = 20000;
    localparam int TIMEOUT_CYC =
        (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_CNT_W = 13;

    // pwm step time, nominal
    localparam int PWM_LSB_NS = 2260;
    localparam int PWM_LSB_CYC = PWM_LSB_NS / CLK_PERIOD_NS;
    localparam int PWM_PERIOD_LSB = 257;
    localparam int PWM_CNT_W = 9;

    // serial frame layout in clocks
    localparam int CMD_BITS = 5;
    localparam int DRIVE_END_EDGE = 21;
    localparam int FRAME_CLOCKS = 22;
    localparam int FRAME_BITS = 21;
    localparam int EDGE_CNT_W = 5;
    localparam logic [4:0] CMD_READ_ANGLE = 5'h00;
    localparam logic [4:0] FRAME_LEAD = 5'h00;

    // two-entry buffer
    localparam int BUF_DEPTH = 2;

    typedef struct packed {
        logic lock;
        logic [5:0] gain_control_code;
        logic [7:0] angle;
    } meas_t;

    typedef struct packed {
        logic [4:0] lead;
        logic wire_mode;
        logic lock;
        logic [5:0] gain_control_code;
        logic [7:0] angle;
    } frame_t;

    typedef enum {
        SER_IDLE,
        SER_CMD,
        SER_DATA,
        SER_TAIL,
        SER_SKIP,
        SER_CHAIN
    } ser_state_t;

endpackage

// ==== logic/meas_buffer.sv ====
`timescale 1ns/10ps
module meas_buffer #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [$clog2(DEPTH)-1:0] wr_ptr;
    logic [$clog2(DEPTH)-1:0] rd_ptr;
    logic [$clog2(DEPTH):0] count;
    logic push;
    logic pop;

    assign in_ready = (count != ($clog2(DEPTH)+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + {{$clog2(DEPTH){1'b0}}, push}
                - {{$clog2(DEPTH){1'b0}}, pop};
        end
    end
endmodule

// ==== logic/angle_serial_pwm_readout.sv ====
// Behaviour
// RL1: data line is an input during the five command bits of each frame; the code drives it as soon as chip select is active when daisy_enable is set.
// RL2: five zero command bits run the angle read and shift out the word.
// RL3: in 2-wire mode clock timeout produces chip select on its own pin.
// RL4: each clock timeout resets the serial logic; frame ends after clock 22.
// RL5: without timeout, clock 23 starts the next frame; readings stream on.
// RL6: controller may resynchronise by a timeout after any number of readings.
// RL7: frame is five zeros, wire mode, lock, gain code, angle: 21 bits.
// RL8: pwm high is angle plus one step, period is 257 steps.
// RL9: invalid angle holds pwm low with no pulses.
// RL10: frozen gain control makes pwm invalid.
// RL11: in a chain each downstream frame follows the upstream one directly.
// RL12: last 2-wire device's generated select drives the first's select input.
// RL13: 2-wire chain needs one extra leading clock from the controller.
// RL14: controller idles clock over 24 us after the chain to restart it.
// RL15: lock flag is set only while gain control is locked.
// RL16: wire mode pin low selects 3-wire, high selects 2-wire operation.
// RL17: every transaction starts with a 5-bit command, then data bits.
// RL18: frame goes out msb first, one bit per rising serial clock edge.
// RL19: data output is released whenever chip select is inactive.
`timescale 1ns/10ps
module angle_serial_pwm_readout (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic link_sclk,
    input wire logic serial_data_io_in,
    output logic serial_data_io_out,
    output logic serial_data_io_oe_low,
    input wire logic chain_data_in,
    input wire logic select_in_low,
    output logic generated_select_out,
    input wire logic wire_mode_pin,
    input wire logic daisy_enable,
    input wire logic meas_valid,
    output logic meas_ready,
    input wire angle_readout_pkg::meas_t meas,
    input wire logic gain_frozen,
    output logic pwm_out,
    output logic frame_active
);

    // link domain: reset catch, edge toggle and sampled bits
    logic link_rst_meta;
    logic link_rst_n;
    logic link_toggle;
    logic link_data_bit;
    logic link_chain_bit;

    always_ff @(posedge link_sclk) begin
        link_rst_meta <= rst_n;
        link_rst_n <= link_rst_meta;
    end

    always_ff @(posedge link_sclk) begin
        if (!link_rst_n) begin
            link_toggle <= 1'b0;
            link_data_bit <= 1'b0;
            link_chain_bit <= 1'b0;
        end else begin
            link_toggle <= ~link_toggle;
            link_data_bit <= serial_data_io_in;
            link_chain_bit <= chain_data_in;
        end
    end

    // pin synchronisers
    logic tog_meta;
    logic tog_sync;
    logic tog_prev;
    logic sel_meta;
    logic sel_sync_low;
    logic mode_meta;
    logic mode_sync;
    logic daisy_meta;
    logic daisy_sync;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_prev <= 1'b0;
        end else begin
            tog_meta <= link_toggle;
            tog_sync <= tog_meta;
            tog_prev <= tog_sync;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sel_meta <= 1'b1;
            sel_sync_low <= 1'b1;
            mode_meta <= 1'b0;
            mode_sync <= 1'b0;
            daisy_meta <= 1'b0;
            daisy_sync <= 1'b0;
        end else begin
            sel_meta <= select_in_low;
            sel_sync_low <= sel_meta;
            mode_meta <= wire_mode_pin;
            mode_sync <= mode_meta;
            daisy_meta <= daisy_enable;
            daisy_sync <= daisy_meta;
        end
    end

    // one pulse per rising serial clock edge; sampled bits stand until next
    logic sclk_edge;
    assign sclk_edge = tog_sync ^ tog_prev;

    // clock idle timeout
    localparam int IDLE_CNT_W_FIX = angle_readout_pkg::IDLE_CNT_W;
    logic [IDLE_CNT_W_FIX-1:0] idle_cnt;
    localparam logic [IDLE_CNT_W_FIX-1:0] IDLE_LAST =
        IDLE_CNT_W_FIX'(angle_readout_pkg::TIMEOUT_CYC - 1);
    logic timed_out;
    logic timeout_pulse;

    assign timeout_pulse = !sclk_edge && !timed_out && (idle_cnt == IDLE_LAST);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            idle_cnt <= '0;
            timed_out <= 1'b1;
        end else if (sclk_edge) begin
            idle_cnt <= '0;
            timed_out <= 1'b0;
        end else if (timeout_pulse) begin
            timed_out <= 1'b1; // [RL3] [RL4]
        end else if (!timed_out) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // generated select, low while a frame runs, same sense as select input
    assign generated_select_out = timed_out; // [RL3] [RL12]

    logic selected;
    logic accept;
    logic frame_reset;

    // 2-wire: select comes from clock activity; 3-wire: external pin
    assign selected = mode_sync ? !timed_out : !sel_sync_low; // [RL16]
    assign accept = sclk_edge && (mode_sync || !sel_sync_low);
    assign frame_reset = timeout_pulse
        || (!mode_sync && sel_sync_low); // [RL4] [RL6]

    // measurement buffer and current word
    angle_readout_pkg::meas_t buf_data;
    angle_readout_pkg::meas_t meas_cur;
    logic buf_valid;
    logic buf_take;
    angle_readout_pkg::ser_state_t state;

    // word stays fixed while a frame is being shifted
    assign buf_take = (state == angle_readout_pkg::SER_IDLE);

    meas_buffer #(
        .WIDTH($bits(angle_readout_pkg::meas_t)),
        .DEPTH(angle_readout_pkg::BUF_DEPTH)
    ) u_meas_buffer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(meas_valid),
        .in_ready(meas_ready),
        .in_data(meas),
        .out_valid(buf_valid),
        .out_ready(buf_take),
        .out_data(buf_data)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meas_cur <= '0;
        end else if (buf_valid && buf_take) begin
            meas_cur <= buf_data;
        end
    end

    // serial frame sequencing
    localparam int EDGE_W = angle_readout_pkg::EDGE_CNT_W;
    logic [EDGE_W-1:0] edge_cnt;
    logic [4:0] cmd;
    logic [4:0] next_cmd;

    assign next_cmd = {cmd[3:0], link_data_bit};

    always_ff @(posedge sys_clk) begin
        if (!rst_n || frame_reset) begin
            state <= angle_readout_pkg::SER_IDLE; // [RL4]
            edge_cnt <= '0;
            cmd <= '0;
        end else if (accept) begin
            case (state)
                angle_readout_pkg::SER_IDLE: begin
                    edge_cnt <= EDGE_W'(1);
                    cmd <= next_cmd; // [RL17]
                    if (daisy_sync) begin
                        state <= angle_readout_pkg::SER_CHAIN; // [RL11]
                    end else begin
                        state <= angle_readout_pkg::SER_CMD;
                    end
                end
                angle_readout_pkg::SER_CMD: begin
                    edge_cnt <= edge_cnt + 1'b1;
                    cmd <= next_cmd; // [RL17]
                    if (edge_cnt ==
                        EDGE_W'(angle_readout_pkg::CMD_BITS - 1)) begin
                        if (next_cmd ==
                            angle_readout_pkg::CMD_READ_ANGLE) begin
                            state <= angle_readout_pkg::SER_DATA; // [RL2]
                        end else begin
                            state <= angle_readout_pkg::SER_SKIP;
                        end
                    end
                end
                angle_readout_pkg::SER_DATA: begin
                    edge_cnt <= edge_cnt + 1'b1;
                    if (edge_cnt ==
                        EDGE_W'(angle_readout_pkg::DRIVE_END_EDGE - 1)) begin
                        state <= angle_readout_pkg::SER_TAIL;
                    end
                end
                angle_readout_pkg::SER_TAIL,
                angle_readout_pkg::SER_SKIP: begin
                    edge_cnt <= edge_cnt + 1'b1;
                    if (edge_cnt ==
                        EDGE_W'(angle_readout_pkg::FRAME_CLOCKS - 1)) begin
                        state <= angle_readout_pkg::SER_IDLE; // [RL5]
                        edge_cnt <= '0;
                    end
                end
                angle_readout_pkg::SER_CHAIN: begin
                    if (edge_cnt !=
                        EDGE_W'(angle_readout_pkg::FRAME_BITS)) begin
                        edge_cnt <= edge_cnt + 1'b1;
                    end
                end
                default: begin
                    state <= angle_readout_pkg::SER_IDLE;
                    edge_cnt <= '0;
                end
            endcase
        end
    end

    // frame word and shifter; downstream bits enter at the bottom
    angle_readout_pkg::frame_t frame_word;
    angle_readout_pkg::frame_t frame_shift;

    always_comb begin
        frame_word.lead = angle_readout_pkg::FRAME_LEAD; // [RL7]
        frame_word.wire_mode = mode_sync;
        frame_word.lock = meas_cur.lock; // [RL15]
        frame_word.gain_control_code = meas_cur.gain_control_code;
        frame_word.angle = meas_cur.angle;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            frame_shift <= '0;
        end else if (accept && !frame_reset) begin
            frame_shift <= {frame_shift[19:0],
                link_chain_bit}; // [RL18] [RL11]
        end else if (state == angle_readout_pkg::SER_IDLE) begin
            frame_shift <= frame_word; // [RL7]
        end
    end

    // pad drive: only the data phase of a read, or all of a chain frame
    logic drive_now;

    always_comb begin
        drive_now = 1'b0;
        case (state)
            angle_readout_pkg::SER_DATA: drive_now = 1'b1; // [RL2]
            angle_readout_pkg::SER_CHAIN: drive_now = 1'b1;
            angle_readout_pkg::SER_IDLE: drive_now = daisy_sync;
            angle_readout_pkg::SER_CMD: drive_now = 1'b0; // [RL1]
            default: drive_now = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            serial_data_io_out <= 1'b0;
            serial_data_io_oe_low <= 1'b1;
        end else begin
            serial_data_io_out <= frame_shift[angle_readout_pkg::FRAME_BITS-1];
            serial_data_io_oe_low <= !(selected && drive_now
                && !frame_reset); // [RL19] [RL1]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            frame_active <= 1'b0;
        end else begin
            frame_active <= (state != angle_readout_pkg::SER_IDLE);
        end
    end

    // pwm output
    localparam int PW = angle_readout_pkg::PWM_CNT_W;
    logic [PW-1:0] lsb_cnt;
    logic [PW-1:0] step_cnt;
    logic [7:0] pwm_angle;
    logic pwm_valid;
    logic step_end;

    assign step_end = (lsb_cnt == PW'(angle_readout_pkg::PWM_LSB_CYC - 1));

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lsb_cnt <= '0;
        end else if (step_end) begin
            lsb_cnt <= '0;
        end else begin
            lsb_cnt <= lsb_cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            step_cnt <= '0;
            pwm_angle <= '0;
            pwm_valid <= 1'b0;
        end else if (step_end) begin
            if (step_cnt == PW'(angle_readout_pkg::PWM_PERIOD_LSB - 1)) begin
                step_cnt <= '0; // [RL8]
                pwm_angle <= meas_cur.angle;
                pwm_valid <= meas_cur.lock && !gain_frozen; // [RL9] [RL10]
            end else begin
                step_cnt <= step_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pwm_out <= 1'b0;
        end else begin
            // high for angle+1 steps, low for the rest of the period
            pwm_out <= pwm_valid && !gain_frozen
                && (step_cnt <= {1'b0, pwm_angle}); // [RL8] [RL9] [RL10]
        end
    end

endmodule

// ==== test/angle_serial_pwm_readout_properties.sv ====
`timescale 1ns/10ps
module angle_serial_pwm_readout_properties (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic link_sclk,
    input wire logic serial_data_io_oe_low,
    input wire logic select_in_low,
    input wire logic generated_select_out,
    input wire logic wire_mode_pin,
    input wire logic daisy_enable,
    input wire logic meas_ready,
    input wire logic gain_frozen,
    input wire logic pwm_out,
    input wire logic frame_active
);
    localparam int STEP = angle_readout_pkg::PWM_LSB_CYC;
    localparam int HI_MAX = 256 * STEP;
    int hi_cnt;
    int idle_cnt;
    int rise_cnt;
    logic sclk_d;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // pulse length, cycles since a serial clock rise, rises in a frame
    always_ff @(posedge sys_clk) begin
        sclk_d <= link_sclk;
        if (!rst_n) begin
            hi_cnt <= 0;
            idle_cnt <= 0;
            rise_cnt <= 0;
        end else begin
            hi_cnt <= pwm_out ? hi_cnt + 1 : 0;
            if (link_sclk && !sclk_d) begin
                idle_cnt <= 0;
                rise_cnt <= (rise_cnt == 22) ? 1 : rise_cnt + 1;
            end else begin
                idle_cnt <= (idle_cnt < 5000) ? idle_cnt + 1 : idle_cnt;
                if (idle_cnt == 3990) begin
                    rise_cnt <= 0;
                end
            end
        end
    end
    chk_cmd_input: assert property (
        rise_cnt <= 4 && !daisy_enable |-> serial_data_io_oe_low)
        else $error("data pad driven during command bits");
    chk_release_end: assert property (
        rise_cnt == 22 && !daisy_enable |-> serial_data_io_oe_low)
        else $error("data pad still driven after bit zero");
    chk_gen_sel_timeout: assert property (
        idle_cnt == 4020 && wire_mode_pin |-> generated_select_out)
        else $error("generated select not raised by timeout");
    chk_gen_sel_active: assert property (
        idle_cnt == 8 && wire_mode_pin |-> !generated_select_out)
        else $error("generated select high during frame");
    chk_timeout_idle: assert property (
        idle_cnt == 4020 |-> !frame_active)
        else $error("frame still active after timeout");
    chk_frame_start: assert property (
        idle_cnt == 8 && (wire_mode_pin || !select_in_low)
        && (rise_cnt != 22 || daisy_enable) |-> frame_active)
        else $error("frame not active after clock");
    chk_frame_end: assert property (
        rise_cnt == 22 && idle_cnt == 8 && !daisy_enable |-> !frame_active)
        else $error("frame not ended after clock 22");
    chk_pwm_steps: assert property (
        $fell(pwm_out) && !gain_frozen && !$past(gain_frozen)
        |-> hi_cnt % STEP == 0)
        else $error("pwm high time not whole steps");
    chk_pwm_max: assert property (hi_cnt <= HI_MAX)
        else $error("pwm high longer than 256 steps");
    chk_frozen_low: assert property (
        gain_frozen ##1 gain_frozen |-> !pwm_out)
        else $error("pwm high while gain frozen");
    cover property ($fell(pwm_out));
    cover property ($rose(generated_select_out));
    cover property ($fell(meas_ready));
endmodule

// ==== test/sclk_master.sv ====
`timescale 1ns/10ps
module sclk_master (
    output logic link_sclk,
    output logic drive_en,
    output logic drive_val,
    input wire logic line
);
    logic [62:0] got;
    initial begin
        link_sclk = 1'b0;
        drive_en = 1'b0;
        drive_val = 1'b0;
        got = '0;
    end
    // clock runs only inside frames; line sampled just before each rise
    task automatic frame(input int n, input logic [4:0] cmd);
        got = '0;
        for (int i = 0; i < n; i++) begin
            drive_en = (i < 5) && (cmd != 5'h00);
            drive_val = (i < 5) ? cmd[4 - i] : 1'b0;
            #32;
            got = {got[61:0], line};
            link_sclk = 1'b1;
            #12;
            drive_en = 1'b0;
            #20;
            link_sclk = 1'b0;
        end
    endtask
    // clock held still to resynchronise
    task automatic idle();
        #25000;
    endtask
endmodule

// ==== test/angle_serial_pwm_readout_bench.sv ====
`timescale 1ns/10ps
module angle_serial_pwm_readout_bench;
    logic sys_clk, rst_n, link_sclk, dio_out, dio_oe_low, dio_line;
    logic drive_en, drive_val, chain_data_in, sel_drv, select_in_low;
    logic gen_sel, wire_mode_pin, daisy_enable, meas_valid, meas_ready;
    logic gain_frozen, pwm_out, frame_active;
    angle_readout_pkg::meas_t meas;
    int fails;
    int check_count;
    // released pad falls to the pull-down level
    assign dio_line = !dio_oe_low ? dio_out : (drive_en ? drive_val : 1'b0);
    assign select_in_low = wire_mode_pin ? gen_sel : sel_drv;
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    sclk_master ctl (.link_sclk(link_sclk), .drive_en(drive_en),
        .drive_val(drive_val), .line(dio_line));
    angle_serial_pwm_readout uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .link_sclk(link_sclk), .serial_data_io_in(dio_line),
        .serial_data_io_out(dio_out), .serial_data_io_oe_low(dio_oe_low),
        .chain_data_in(chain_data_in), .select_in_low(select_in_low),
        .generated_select_out(gen_sel), .wire_mode_pin(wire_mode_pin),
        .daisy_enable(daisy_enable), .meas_valid(meas_valid),
        .meas_ready(meas_ready), .meas(meas), .gain_frozen(gain_frozen),
        .pwm_out(pwm_out), .frame_active(frame_active));
    task automatic check(input logic [62:0] seen, input logic [62:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [20:0] fr(input logic wm, input logic [14:0] w);
        return {5'h00, wm, w};
    endfunction
    task automatic mode(input logic wm, input logic dc, input logic sl);
        @(posedge sys_clk);
        wire_mode_pin <= wm;
        daisy_enable <= dc;
        chain_data_in <= dc;
        sel_drv <= sl;
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic push(input logic [14:0] w);
        int k;
        k = 0;
        @(posedge sys_clk);
        meas <= w;
        meas_valid <= 1'b1;
        @(negedge sys_clk);
        while (meas_ready !== 1'b1 && k < 200) begin
            @(negedge sys_clk);
            k++;
        end
        @(posedge sys_clk);
        meas_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic t_read3();
        mode(1'b0, 1'b0, 1'b1);
        check(dio_oe_low, 1'b1);
        push(15'h6a5c);
        mode(1'b0, 1'b0, 1'b0);
        ctl.frame(22, 5'h00);
        check(ctl.got, {fr(1'b0, 15'h6a5c), 1'b0});
        mode(1'b0, 1'b0, 1'b1);
        check(dio_oe_low, 1'b1);
        ctl.idle();
        $display("three wire read done");
    endtask
    task automatic t_read2();
        mode(1'b1, 1'b0, 1'b1);
        push(15'h4133);
        ctl.idle();
        check(gen_sel, 1'b1);
        ctl.frame(43, 5'h00);
        check(frame_active, 1'b1);
        check(gen_sel, 1'b0);
        check(ctl.got, {fr(1'b1, 15'h4133), 1'b0,
            fr(1'b1, 15'h4133)});
        ctl.idle();
        check(frame_active, 1'b0);
        check(gen_sel, 1'b1);
        $display("two wire stream done");
    endtask
    task automatic t_cmd();
        mode(1'b0, 1'b0, 1'b0);
        ctl.frame(22, 5'h15);
        check(ctl.got, {5'h15, 17'h0});
        mode(1'b0, 1'b0, 1'b1);
        ctl.idle();
        $display("other command done");
    endtask
    task automatic t_chain();
        mode(1'b0, 1'b1, 1'b0);
        ctl.frame(42, 5'h00);
        check(ctl.got, {fr(1'b0, 15'h4133), 21'h1fffff});
        mode(1'b0, 1'b1, 1'b1);
        ctl.idle();
        mode(1'b0, 1'b0, 1'b0);
        $display("chain done");
    endtask
    task automatic t_chain2();
        mode(1'b1, 1'b1, 1'b1);
        ctl.frame(43, 5'h00);
        check(ctl.got, {fr(1'b1, 15'h4133), 22'h3fffff});
        ctl.idle();
        check(gen_sel, 1'b1);
        mode(1'b0, 1'b0, 1'b0);
        $display("two wire chain done");
    endtask
    task automatic t_buf();
        fork
            ctl.frame(22, 5'h00);
            begin
                repeat (20) @(posedge sys_clk);
                push(15'h7f01);
                push(15'h40a7);
                @(negedge sys_clk);
                check(meas_ready, 1'b0);
            end
        join
        check(ctl.got, {fr(1'b0, 15'h4133), 1'b0});
        mode(1'b0, 1'b0, 1'b1);
        ctl.idle();
        check(meas_ready, 1'b1);
        mode(1'b0, 1'b0, 1'b0);
        ctl.frame(22, 5'h00);
        check(ctl.got, {fr(1'b0, 15'h40a7), 1'b0});
        mode(1'b0, 1'b0, 1'b1);
        $display("buffer done");
    endtask
    task automatic t_pwm();
        int k;
        int n;
        k = 0;
        n = 0;
        push(15'h4001);
        @(negedge sys_clk);
        while (pwm_out === 1'b1 && k < 240000) begin
            @(negedge sys_clk);
            k++;
        end
        while (pwm_out !== 1'b1 && k < 240000) begin
            @(negedge sys_clk);
            k++;
        end
        while (pwm_out === 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        check(n, 2 * angle_readout_pkg::PWM_LSB_CYC);
        @(posedge sys_clk);
        gain_frozen <= 1'b1;
        repeat (3) @(negedge sys_clk);
        check(pwm_out, 1'b0);
        @(posedge sys_clk);
        gain_frozen <= 1'b0;
        $display("pwm done");
    endtask
    initial begin
        rst_n = 1'b0;
        meas_valid = 1'b0;
        meas = '0;
        wire_mode_pin = 1'b0;
        daisy_enable = 1'b0;
        chain_data_in = 1'b0;
        sel_drv = 1'b1;
        gain_frozen = 1'b0;
        fails = 0;
        check_count = 0;
        ctl.frame(4, 5'h00);
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        ctl.frame(3, 5'h00);
        ctl.idle();
        t_read3();
        t_read2();
        t_cmd();
        t_chain();
        t_chain2();
        t_buf();
        t_pwm();
        end_of_test();
    end
    initial begin
        #2000000;
        fails++;
        end_of_test();
    end
endmodule
bind angle_serial_pwm_readout angle_serial_pwm_readout_properties chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_sclk(link_sclk),
    .serial_data_io_oe_low(serial_data_io_oe_low),
    .select_in_low(select_in_low),
    .generated_select_out(generated_select_out),
    .wire_mode_pin(wire_mode_pin), .daisy_enable(daisy_enable),
    .meas_ready(meas_ready), .gain_frozen(gain_frozen),
    .pwm_out(pwm_out), .frame_active(frame_active));
